// >>> hdl/i2cs_consts.svh
// Constants of the two-wire register port: address, map size, timing.
// Assumes the includer passes every time through the cycle macros.
//
// What this block does
// - Works at 100 and 400 kbit/s with the same protocol.
// - Transmitter changes data only while clock is low; one pulse per bit.
// - Data falling with clock high is start; data rising is stop.
// - Bytes are eight bits, MSB first, each followed by an acknowledge.
// - Slave may hold clock low to stall; master waits for release.
// - Transmitter releases data on ninth pulse; receiver pulls it low.
// - A foreign address byte is never acknowledged.
// - Write: slave acks address, a valid index and in-map data bytes; read: only its address.
// - Write goes start, write address, index, data, each acknowledged.
// - Target register takes the value right after the data acknowledge.
// - Index advances after each written byte for burst writes.
// - An index byte is acknowledged only if it names a real register.
// - Combined read: address, index, repeated start, read address, data.
// - Each master acknowledge advances the index and sends the next byte.
// - Master refusal or stop ends the read and frees the data line.
// - Reads work combined and split; the index survives between frames.
// - Short spikes on clock and data inputs are filtered out.
// - Fixed seven-bit address; last bit one reads, zero writes.
`ifndef I2CS_CONSTS_SVH
`define I2CS_CONSTS_SVH

`define I2CS_SLAVE_ADDR 7'h49
`define I2CS_RW_BIT 0
`define I2CS_NUM_REGS 8'h0E
`define I2CS_IDX_RST 8'h00

`define I2CS_LINK_PERIOD_NS 32
`define I2CS_SPIKE_NS 50
`define I2CS_SPIKE_CYC \
  ((`I2CS_SPIKE_NS + `I2CS_LINK_PERIOD_NS - 1) / `I2CS_LINK_PERIOD_NS)
`define I2CS_SETUP_NS 250
`define I2CS_SETUP_CYC \
  ((`I2CS_SETUP_NS + `I2CS_LINK_PERIOD_NS - 1) / `I2CS_LINK_PERIOD_NS)

`endif

// >>> hdl/i2cs_pkg.sv
// Types of the two-wire register port.
// Assumes nothing of its surroundings.
package i2cs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_ACK = 3'h2,
    ST_WAIT = 3'h3,
    ST_TX = 3'h4,
    ST_MACK = 3'h5
  } i2cs_state_type;
  typedef enum logic [1:0] {
    ROLE_ADDR = 2'h0,
    ROLE_INDEX = 2'h1,
    ROLE_DATA = 2'h2
  } i2cs_role_type;
endpackage : i2cs_pkg

// >>> hdl/i2cs_port.sv
// Two-wire slave port feeding a byte-wide register bank.
// Assumes open-drain pins resolved outside and a bank whose read data
// follows o_reg_addr combinationally on the system clock.
`timescale 1ns/100ps
`include "i2cs_consts.svh"

module i2cs_port #(
  parameter logic [6:0] SLAVE_ADDR = `I2CS_SLAVE_ADDR,
  parameter logic [7:0] NUM_REGS = `I2CS_NUM_REGS
) (
  // System side
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Link side
  input wire logic i_clk_link,
  input wire logic i_scl,
  output logic o_scl_o,
  output logic o_scl_oe_n,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe_n,
  // Register bank
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_wr,
  output logic o_reg_rd,
  input wire logic [7:0] i_reg_rdata
);

  // A spike may span SPIKE_CYC samples, so one more is needed to pass
  localparam logic [3:0] SPK_LAST = 4'(`I2CS_SPIKE_CYC);
  // Counts in link cycles, so both bus rates see the same timing
  localparam logic [3:0] SETUP_CYC = 4'(`I2CS_SETUP_CYC);

  // ****************************************
  // Spike filter step
  // ****************************************
  // Returns {filtered level, run counter}
  function automatic logic [4:0] filt_step(
    input logic raw,
    input logic flt,
    input logic [3:0] cnt
  );
    logic [4:0] r;
    r = {flt, 4'h0};
    if (raw != flt) begin
      if (cnt == SPK_LAST) begin
        r = {raw, 4'h0};
      end else begin
        r = {flt, cnt + 4'h1};
      end
    end
    return r;
  endfunction : filt_step

  // ****************************************
  // Link domain: reset and pin capture
  // ****************************************
  logic lrst_s1_r;
  logic lrst_r;
  logic scl_s1_r;
  logic scl_s2_r;
  logic sda_s1_r;
  logic sda_s2_r;
  logic scl_f_r;
  logic sda_f_r;
  logic scl_p_r;
  logic sda_p_r;
  logic [3:0] scl_cnt_r;
  logic [3:0] sda_cnt_r;
  logic [4:0] scl_nxt;
  logic [4:0] sda_nxt;

  always_ff @(posedge i_clk_link) begin
    lrst_s1_r <= i_srst;
    lrst_r <= lrst_s1_r;
  end

  always_ff @(posedge i_clk_link) begin
    scl_s1_r <= i_scl;
    scl_s2_r <= scl_s1_r;
    sda_s1_r <= i_sda;
    sda_s2_r <= sda_s1_r;
  end

  assign scl_nxt = filt_step(scl_s2_r, scl_f_r, scl_cnt_r);
  assign sda_nxt = filt_step(sda_s2_r, sda_f_r, sda_cnt_r);

  // A level must persist past the spike width to be believed
  always_ff @(posedge i_clk_link) begin
    if (lrst_r) begin
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_cnt_r <= 4'h0;
      sda_cnt_r <= 4'h0;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      {scl_f_r, scl_cnt_r} <= scl_nxt;
      {sda_f_r, sda_cnt_r} <= sda_nxt;
      scl_p_r <= scl_f_r;
      sda_p_r <= sda_f_r;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_f_r & ~scl_p_r;
  assign scl_fall = ~scl_f_r & scl_p_r;
  assign start_det = scl_f_r & scl_p_r & sda_p_r & ~sda_f_r;
  assign stop_det = scl_f_r & scl_p_r & ~sda_p_r & sda_f_r;

  // ****************************************
  // Link domain: protocol engine
  // ****************************************
  i2cs_pkg::i2cs_state_type st_r;
  i2cs_pkg::i2cs_role_type role_r;
  logic [3:0] cnt_r;
  logic [3:0] setup_r;
  logic [7:0] sh_r;
  logic [7:0] tx_sh_r;
  logic [7:0] idx_r;
  logic go_wr_r;
  logic go_rd_r;
  logic mack_r;
  logic scl_oe_n_r;
  logic sda_oe_n_r;
  logic req_r;
  logic req_rd_r;
  logic [7:0] req_addr_r;
  logic [7:0] req_data_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic ack_r;
  logic [7:0] rdata_r;
  logic addr_hit;
  logic idx_ok;
  logic sh_ok;

  assign addr_hit = sh_r[7:1] == SLAVE_ADDR;
  assign idx_ok = idx_r < NUM_REGS;
  assign sh_ok = sh_r < NUM_REGS;

  always_ff @(posedge i_clk_link) begin
    ack_s1_r <= ack_r;
    ack_s2_r <= ack_s1_r;
  end

  // Pins are open drain: only the enables move
  always_ff @(posedge i_clk_link) begin
    if (lrst_r) begin
      st_r <= i2cs_pkg::ST_IDLE;
      role_r <= i2cs_pkg::ROLE_ADDR;
      cnt_r <= 4'h0;
      setup_r <= 4'h0;
      sh_r <= 8'h00;
      tx_sh_r <= 8'h00;
      idx_r <= `I2CS_IDX_RST;
      go_wr_r <= 1'b0;
      go_rd_r <= 1'b0;
      mack_r <= 1'b0;
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
      req_r <= 1'b0;
      req_rd_r <= 1'b0;
      req_addr_r <= 8'h00;
      req_data_r <= 8'h00;
    end else if (start_det) begin
      st_r <= i2cs_pkg::ST_RX;
      role_r <= i2cs_pkg::ROLE_ADDR;
      cnt_r <= 4'h0;
      sda_oe_n_r <= 1'b1;
    end else if (stop_det) begin
      st_r <= i2cs_pkg::ST_IDLE;
      sda_oe_n_r <= 1'b1;
    end else begin
      case (st_r)
        i2cs_pkg::ST_IDLE: begin
          sda_oe_n_r <= 1'b1;
        end
        i2cs_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_f_r};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == 4'h8) begin
            cnt_r <= 4'h0;
            st_r <= i2cs_pkg::ST_IDLE;
            case (role_r)
              i2cs_pkg::ROLE_ADDR: begin
                go_wr_r <= 1'b0;
                go_rd_r <= sh_r[`I2CS_RW_BIT];
                role_r <= i2cs_pkg::ROLE_INDEX;
                if (addr_hit) begin
                  sda_oe_n_r <= 1'b0;
                  st_r <= i2cs_pkg::ST_ACK;
                end
              end
              i2cs_pkg::ROLE_INDEX: begin
                go_wr_r <= 1'b0;
                go_rd_r <= 1'b0;
                role_r <= i2cs_pkg::ROLE_DATA;
                if (sh_ok) begin
                  idx_r <= sh_r;
                  sda_oe_n_r <= 1'b0;
                  st_r <= i2cs_pkg::ST_ACK;
                end
              end
              default: begin
                go_wr_r <= idx_ok;
                go_rd_r <= 1'b0;
                if (idx_ok) begin
                  sda_oe_n_r <= 1'b0;
                  st_r <= i2cs_pkg::ST_ACK;
                end
              end
            endcase
          end
        end
        i2cs_pkg::ST_ACK: begin
          if (scl_fall) begin
            sda_oe_n_r <= 1'b1;
            cnt_r <= 4'h0;
            if (go_wr_r || go_rd_r) begin
              // Hold the clock until the bank has answered
              st_r <= i2cs_pkg::ST_WAIT;
              scl_oe_n_r <= 1'b0;
              req_r <= ~req_r;
              req_rd_r <= go_rd_r;
              req_addr_r <= idx_r;
              req_data_r <= sh_r;
            end else begin
              st_r <= i2cs_pkg::ST_RX;
            end
          end
        end
        i2cs_pkg::ST_WAIT: begin
          if (setup_r != 4'h0) begin
            // Data must settle before the clock is let go
            setup_r <= setup_r - 4'h1;
            if (setup_r == 4'h1) begin
              scl_oe_n_r <= 1'b1;
              st_r <= req_rd_r ? i2cs_pkg::ST_TX : i2cs_pkg::ST_RX;
            end
          end else if (ack_s2_r == req_r) begin
            setup_r <= SETUP_CYC;
            cnt_r <= 4'h0;
            if (req_rd_r) begin
              tx_sh_r <= rdata_r;
              sda_oe_n_r <= rdata_r[7];
            end else begin
              idx_r <= idx_r + 8'h01;
              role_r <= i2cs_pkg::ROLE_DATA;
            end
          end
        end
        i2cs_pkg::ST_TX: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == 4'h8) begin
              sda_oe_n_r <= 1'b1;
              st_r <= i2cs_pkg::ST_MACK;
            end else begin
              tx_sh_r <= {tx_sh_r[6:0], 1'b0};
              sda_oe_n_r <= tx_sh_r[6];
            end
          end
        end
        i2cs_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_f_r;
          end else if (scl_fall) begin
            if (mack_r) begin
              idx_r <= idx_r + 8'h01;
              st_r <= i2cs_pkg::ST_WAIT;
              scl_oe_n_r <= 1'b0;
              req_r <= ~req_r;
              req_rd_r <= 1'b1;
              req_addr_r <= idx_r + 8'h01;
            end else begin
              st_r <= i2cs_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          st_r <= i2cs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign o_scl_o = 1'b0;
  assign o_sda_o = 1'b0;
  assign o_scl_oe_n = scl_oe_n_r;
  assign o_sda_oe_n = sda_oe_n_r;

  // ****************************************
  // System domain: register bank access
  // ****************************************
  logic req_s1_r;
  logic req_s2_r;
  logic req_s3_r;
  logic rd_pend_r;
  logic req_evt;

  always_ff @(posedge i_clk_sys) begin
    req_s1_r <= req_r;
    req_s2_r <= req_s1_r;
  end

  // Request fields are held still by the link until the ack returns
  assign req_evt = req_s2_r ^ req_s3_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      req_s3_r <= 1'b0;
      o_reg_addr <= 8'h00;
      o_reg_wdata <= 8'h00;
      o_reg_wr <= 1'b0;
      o_reg_rd <= 1'b0;
      rd_pend_r <= 1'b0;
      rdata_r <= 8'h00;
      ack_r <= 1'b0;
    end else begin
      req_s3_r <= req_s2_r;
      o_reg_wr <= req_evt & ~req_rd_r;
      o_reg_rd <= req_evt & req_rd_r;
      rd_pend_r <= req_evt & req_rd_r;
      if (req_evt) begin
        o_reg_addr <= req_addr_r;
        o_reg_wdata <= req_data_r;
      end
      if (req_evt && !req_rd_r) begin
        ack_r <= ~ack_r;
      end
      if (rd_pend_r) begin
        // Past the map the port reads zero
        rdata_r <= (o_reg_addr < NUM_REGS) ? i_reg_rdata : 8'h00;
        ack_r <= ~ack_r;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  wr_strobe_a: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    req_evt && !req_rd_r |=> o_reg_wr ##1 !o_reg_wr)
    else $error("write strobe not a single cycle after request");

  stretch_hold_a: assert property (
    @(posedge i_clk_link) disable iff (lrst_r)
    st_r == i2cs_pkg::ST_WAIT && ack_s2_r != req_r |-> !o_scl_oe_n)
    else $error("clock released before the bank answered");

  sda_steady_a: assert property (
    @(posedge i_clk_link) disable iff (lrst_r)
    scl_f_r && scl_p_r && $past(scl_p_r) &&
    !$past(start_det || stop_det) |-> $stable(o_sda_oe_n))
    else $error("data moved while clock high");

  foreign_nack_a: assert property (
    @(posedge i_clk_link) disable iff (lrst_r)
    st_r == i2cs_pkg::ST_RX && role_r == i2cs_pkg::ROLE_ADDR &&
    scl_fall && cnt_r == 4'h8 && !addr_hit
    |=> o_sda_oe_n && st_r == i2cs_pkg::ST_IDLE)
    else $error("foreign address acknowledged");

  bad_index_a: assert property (
    @(posedge i_clk_link) disable iff (lrst_r)
    st_r == i2cs_pkg::ST_RX && role_r == i2cs_pkg::ROLE_INDEX &&
    scl_fall && cnt_r == 4'h8 && !sh_ok |=> o_sda_oe_n [*2])
    else $error("invalid index acknowledged");

  restart_a: assert property (
    @(posedge i_clk_link) disable iff (lrst_r)
    start_det |=> st_r == i2cs_pkg::ST_RX &&
    role_r == i2cs_pkg::ROLE_ADDR && cnt_r == 4'h0)
    else $error("start did not rearm address reception");

  stop_idle_a: assert property (
    @(posedge i_clk_link) disable iff (lrst_r)
    stop_det |=> st_r == i2cs_pkg::ST_IDLE && o_sda_oe_n)
    else $error("stop did not free the port");

  tx_release_a: assert property (
    @(posedge i_clk_link) disable iff (lrst_r)
    st_r == i2cs_pkg::ST_TX && scl_fall && cnt_r == 4'h8
    |=> o_sda_oe_n && st_r == i2cs_pkg::ST_MACK)
    else $error("data not released for master acknowledge");

  mack_inc_a: assert property (
    @(posedge i_clk_link) disable iff (lrst_r)
    st_r == i2cs_pkg::ST_MACK && scl_fall && mack_r
    |=> idx_r == $past(idx_r) + 8'h01 && !o_scl_oe_n)
    else $error("index not advanced after master acknowledge");

  nack_end_a: assert property (
    @(posedge i_clk_link) disable iff (lrst_r)
    st_r == i2cs_pkg::ST_MACK && scl_fall && !mack_r
    |=> st_r == i2cs_pkg::ST_IDLE && o_sda_oe_n)
    else $error("read not ended on master refusal");

  wr_inc_a: assert property (
    @(posedge i_clk_link) disable iff (lrst_r)
    st_r == i2cs_pkg::ST_WAIT && setup_r == 4'h0 &&
    ack_s2_r == req_r && !req_rd_r
    |=> idx_r == $past(idx_r) + 8'h01)
    else $error("index not advanced after write");

endmodule : i2cs_port

// >>> tb/i2cs_host.sv
// Two-wire bus master model that drives the slave port from the bench.
// Assumes the bench resolves both wires with pull-ups from all enables.
`timescale 1ns/100ps

module i2cs_host #(
  parameter int QTR_NS = 625
) (
  // Resolved wire levels
  input wire logic i_scl,
  input wire logic i_sda,
  // Drive, 1 releases the wire; o_hang 1 flags a clock never released
  output logic o_scl,
  output logic o_sda,
  output logic o_hang
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    o_hang = 1'b0;
  end

  // ****
  // Bit level
  // ****
  // Waiting on the wire, not the timer, lets the slave stretch
  task automatic clk_high();
    int n;
    o_scl = 1'b1;
    n = 0;
    while (i_scl !== 1'b1 && n < 5000) begin
      #10;
      n++;
    end
    if (n >= 5000) o_hang = 1'b1;
    #(QTR_NS);
  endtask : clk_high

  task automatic put_bit(input logic b, output logic seen);
    #(QTR_NS);
    o_sda = b;
    #(QTR_NS);
    clk_high();
    seen = i_sda;
    #(QTR_NS);
    o_scl = 1'b0;
  endtask : put_bit

  task automatic start();
    #(QTR_NS);
    o_sda = 1'b1;
    #(QTR_NS);
    clk_high();
    o_sda = 1'b0;
    #(QTR_NS);
    o_scl = 1'b0;
  endtask : start

  task automatic stop();
    #(QTR_NS);
    o_sda = 1'b0;
    #(QTR_NS);
    clk_high();
    o_sda = 1'b1;
    #(4 * QTR_NS);
  endtask : stop

  task automatic spike(input int ns);
    o_scl = ~o_scl;
    #(ns);
    o_scl = ~o_scl;
  endtask : spike

  // ****
  // Byte level
  // ****
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte

  task automatic get_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(~mack, s);
  endtask : get_byte
endmodule : i2cs_host

// >>> tb/tb_top.sv
// Self-checking bench: host model on the wires, byte bank on the side.
// Assumes the port's default address and map size.
`timescale 1ns/100ps

module tb_top;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] dat;
  } i2cs_row_type;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic srst = 1'b1;
  logic h_scl, h_sda, hang;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, rdata;
  logic [7:0] bank [0:13];
  logic [7:0] expv [0:255];
  int n_errors = 0;
  int num_checks = 0;
  int wr_cnt = 0;
  int exp_wr = 0;
  int rd_cnt = 0;
  int exp_rd = 0;
  i2cs_row_type rows [3] = '{'{8'h00, 8'hA5}, '{8'h07, 8'h81},
    '{8'h0E, 8'h77}};
  wire scl = h_scl & (scl_oe_n | scl_o);
  wire sda = h_sda & (sda_oe_n | sda_o);

  always #4 clk_sys = ~clk_sys;
  always #16 clk_link = ~clk_link;

  i2cs_host u_host (.i_scl(scl), .i_sda(sda), .o_scl(h_scl),
    .o_sda(h_sda), .o_hang(hang));

  i2cs_port DUT (.i_clk_sys(clk_sys), .i_srst(srst),
    .i_clk_link(clk_link), .i_scl(scl), .o_scl_o(scl_o),
    .o_scl_oe_n(scl_oe_n), .i_sda(sda), .o_sda_o(sda_o),
    .o_sda_oe_n(sda_oe_n), .o_reg_addr(reg_addr),
    .o_reg_wdata(reg_wdata), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
    .i_reg_rdata(rdata));

  // ****
  // Register bank stand-in
  // ****
  // Data is only valid while the read strobe stands
  assign rdata = (reg_rd !== 1'b1) ? 8'hXX :
    (reg_addr < 8'h0E) ? bank[reg_addr] : 8'h00;
  always @(posedge clk_sys) begin
    if (reg_rd === 1'b1) rd_cnt++;
    if (reg_wr === 1'b1) begin
      wr_cnt++;
      if (reg_addr < 8'h0E) bank[reg_addr] <= reg_wdata;
    end
  end

  // ****
  // Checks and frames
  // ****
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk_bit(input string what, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit

  task automatic chk_byte(input string what, input logic [7:0] e,
    input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk_byte

  // Spikes just under the filter width would add a bit if they got through
  task automatic wr(input logic [7:0] idx, input logic [7:0] d0,
    input int n, input logic glitch);
    logic a;
    u_host.start();
    if (glitch) begin
      #300;
      // Three phases against the link clock, so one spike spans two samples
      repeat (3) begin
        u_host.spike(47);
        #28;
      end
    end
    u_host.send_byte(8'h92, a);
    chk_bit("write addr ack", 1'b1, a);
    u_host.send_byte(idx, a);
    chk_bit("index ack", idx < 8'h0E, a);
    for (int k = 0; k < n && a; k++) begin
      u_host.send_byte(d0 + 8'(k), a);
      chk_bit("data ack", (idx + k) < 14, a);
      if (a) begin
        expv[8'(idx + k)] = d0 + 8'(k);
        exp_wr++;
      end
    end
    u_host.stop();
  endtask : wr

  task automatic rd(input logic [7:0] idx, input int n, input logic split);
    logic a;
    logic [7:0] d;
    exp_rd += n;
    u_host.start();
    u_host.send_byte(8'h92, a);
    u_host.send_byte(idx, a);
    chk_bit("read index ack", 1'b1, a);
    if (split) u_host.stop();
    u_host.start();
    u_host.send_byte(8'h93, a);
    chk_bit("read addr ack", 1'b1, a);
    for (int k = 0; k < n; k++) begin
      u_host.get_byte(k < n - 1, d);
      chk_byte("read data", expv[8'(idx + k)], d);
    end
    u_host.stop();
    chk_bit("sda released", 1'b1, sda_oe_n);
  endtask : rd

  always @(posedge hang) begin
    n_errors++;
    give_verdict();
  end

  // ****
  // Sequence
  // ****
  initial begin
    logic a;
    foreach (bank[i]) bank[i] = 8'h00;
    foreach (expv[i]) expv[i] = 8'h00;
    repeat (16) @(posedge clk_sys);
    #1;
    chk_bit("scl oe_n in reset", 1'b1, scl_oe_n);
    chk_bit("sda oe_n in reset", 1'b1, sda_oe_n);
    chk_bit("write strobe in reset", 1'b0, reg_wr);
    chk_bit("read strobe in reset", 1'b0, reg_rd);
    chk_byte("addr in reset", 8'h00, reg_addr);
    srst = 1'b0;
    repeat (40) @(posedge clk_sys);
    foreach (rows[r]) begin
      wr(rows[r].idx, rows[r].dat, 1, 1'b0);
      if (rows[r].idx < 8'h0E)
        chk_byte("bank", rows[r].dat, bank[rows[r].idx[3:0]]);
    end
    // Foreign address, then a byte that must be ignored
    u_host.start();
    u_host.send_byte(8'h94, a);
    chk_bit("foreign ack", 1'b0, a);
    u_host.send_byte(8'h01, a);
    chk_bit("ignored byte ack", 1'b0, a);
    u_host.stop();
    wr(8'h0B, 8'hC1, 4, 1'b0);
    rd(8'h0A, 5, 1'b0);
    rd(8'h07, 2, 1'b1);
    // Stop inside a data byte must drop it
    u_host.start();
    u_host.send_byte(8'h92, a);
    u_host.send_byte(8'h00, a);
    repeat (4) u_host.put_bit(1'b0, a);
    u_host.stop();
    rd(8'h00, 1, 1'b0);
    wr(8'h05, 8'h66, 1, 1'b1);
    chk_byte("bank after spike", 8'h66, bank[5]);
    chk_byte("write count", 8'(exp_wr), 8'(wr_cnt));
    chk_byte("read count", 8'(exp_rd), 8'(rd_cnt));
    give_verdict();
  end
endmodule : tb_top
